//--- spi_frame_slave.sv
// 16-bit register-access serial slave, clock mode 0, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module spi_frame_slave #(
	parameter int         TIMEOUT_CYC = spi_frame_pkg::CS_TIMEOUT_NS / spi_frame_pkg::CLK_PERIOD_NS,
	parameter logic [7:0] INFO_ID_VAL = 8'h5A, // Arbitrary identification value
	parameter logic [7:0] INFO_WD_VAL = 8'h00, // Watchdog information byte
	parameter int         FIFO_W      = spi_frame_pkg::FRAME_BITS,
	parameter int         FIFO_D      = spi_frame_pkg::FIFO_DEPTH
) (
	input  wire logic                            clk,             // System clock, 10 MHz
	input  wire logic                            srst,            // Synchronous reset, active high
	input  wire logic                            chip_select_low, // Chip select pin, active low
	input  wire logic                            sck,             // Serial clock pin
	input  wire logic                            sdi,             // Serial data in pin
	output logic                                 sdo_out,         // Serial data out level
	output logic                                 sdo_oe_n,        // Output enable, low drives
	input  wire logic                            flag_fe,         // Functional error summary
	input  wire logic                            flag_de,         // Device error summary
	input  wire logic                            flag_gw,         // Global warning summary
	input  wire logic                            flag_fs,         // Fail-safe summary
	input  wire logic [spi_frame_pkg::STAT_N*8-1:0] status_event, // Status set pulses
	output logic      [spi_frame_pkg::CTRL_N*8-1:0] ctrl_regs,    // Control register contents
	output logic      [spi_frame_pkg::STAT_N*8-1:0] status_regs,  // Status register contents
	output logic                                 interface_error_bit, // Link error flag
	output logic                                 cmd_valid,       // Executed frame available
	output logic      [FIFO_W-1:0]               cmd_data,        // Executed frame word
	input  wire logic                            cmd_ready        // Consumer takes frame word
);
	localparam int CN = spi_frame_pkg::CTRL_N;
	localparam int SN = spi_frame_pkg::STAT_N;
	localparam int TW = spi_frame_pkg::TO_CNT_W;

	logic [2:0]                pins_s;
	logic                      cs_s;
	logic                      sck_s;
	logic                      sdi_s;
	logic                      cs_d_r;
	logic                      sck_d_r;
	logic                      active_r;
	logic                      timeout_r;
	logic [spi_frame_pkg::CNT_W-1:0] bit_cnt_r;
	logic [15:0]               rx_r;
	logic [15:0]               tx_r;
	logic [TW-1:0]             to_cnt_r;
	logic [SN*8-1:0]           snap_r;
	logic                      pend_r;
	logic [15:0]               pend_word_r;
	logic                      rst_flag_r;
	logic                      cs_fall;
	logic                      cs_rise;
	logic                      sck_rise;
	logic                      sck_fall;
	logic                      frame_ok;
	logic                      frame_bad;
	logic                      to_event;
	logic                      exec;
	logic                      fifo_in_ready;
	logic [6:0]                status_low;
	logic [7:0]                global_status_byte;
	logic [7:0]                hdr;
	logic [1:0]                ex_op;
	logic [5:0]                ex_addr;
	logic [7:0]                ex_data;
	logic [SN*8-1:0]           clr_mask;

	// Address decode shared by response and execution
	function automatic logic ctrl_hit(input logic [5:0] a, input int i);
		ctrl_hit = (a == spi_frame_pkg::CTRL_BASE + 6'(i));
	endfunction

	function automatic logic stat_hit(input logic [5:0] a, input int i);
		stat_hit = (a == spi_frame_pkg::STAT_BASE + 6'(i));
	endfunction

	function automatic logic [7:0] respond(input logic [7:0] h, input logic [CN*8-1:0] c,
			input logic [SN*8-1:0] s);
		logic [7:0] v;
		v = 8'h00;
		if (h[7:6] == spi_frame_pkg::OP_INFO) begin
			case (h[5:0])
				spi_frame_pkg::INFO_ID_ADDR:  v = INFO_ID_VAL;
				spi_frame_pkg::INFO_SPI_ADDR: v = spi_frame_pkg::INFO_SPI_VAL;
				spi_frame_pkg::INFO_WD_ADDR:  v = INFO_WD_VAL;
				default:                      v = 8'h00;
			endcase
		end else begin
			for (int i = 0; i < CN; i++) begin
				if (ctrl_hit(h[5:0], i)) begin
					v = c[i*8 +: 8];
				end
			end
			for (int i = 0; i < SN; i++) begin
				if (stat_hit(h[5:0], i)) begin
					v = s[i*8 +: 8];
				end
			end
		end
		respond = v;
	endfunction

	sync2 #(
		.W       (3),
		.RST_VAL (spi_frame_pkg::PIN_IDLE)
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({chip_select_low, sck, sdi}),
		.q    (pins_s)
	);

	assign cs_s  = pins_s[2];
	assign sck_s = pins_s[1];
	assign sdi_s = pins_s[0];

	// Edges are found on the synchronised copies; the link runs far below clk
	assign cs_fall  = cs_d_r && !cs_s;
	assign cs_rise  = !cs_d_r && cs_s;
	assign sck_rise = active_r && !timeout_r && !sck_d_r && sck_s;
	assign sck_fall = active_r && !timeout_r && sck_d_r && !sck_s;
	assign to_event = active_r && !timeout_r && (to_cnt_r == TW'(TIMEOUT_CYC - 1));

	// Stuck input shows as all zeros or all ones over a full frame
	assign frame_ok = cs_rise && active_r && !timeout_r && (bit_cnt_r == 5'd16)
		&& (rx_r != 16'h0000) && (rx_r != 16'hFFFF);
	assign frame_bad = cs_rise && active_r && !frame_ok
		&& !((bit_cnt_r == 5'd0) && !timeout_r);

	assign status_low = {rst_flag_r, interface_error_bit, 1'b0, flag_fe, flag_de, flag_gw, flag_fs};
	assign global_status_byte = {~|status_low, status_low};
	assign hdr = {rx_r[6:0], sdi_s};

	always_ff @(posedge clk) begin
		if (srst) begin
			cs_d_r  <= 1'b1;
			sck_d_r <= 1'b0;
		end else begin
			cs_d_r  <= cs_s;
			sck_d_r <= sck_s;
		end
	end

	// Frame window and timeout
	always_ff @(posedge clk) begin
		if (srst) begin
			active_r  <= 1'b0;
			timeout_r <= 1'b0;
			to_cnt_r  <= '0;
		end else if (cs_fall) begin
			active_r  <= 1'b1;
			timeout_r <= 1'b0;
			to_cnt_r  <= '0;
		end else if (cs_rise) begin
			active_r  <= 1'b0;
			timeout_r <= 1'b0;
			to_cnt_r  <= '0;
		end else if (to_event) begin
			timeout_r <= 1'b1;
		end else if (active_r && !timeout_r) begin
			to_cnt_r <= to_cnt_r + 1'b1;
		end
	end

	// Receive shifter and pulse counter; saturates so long frames stay invalid
	always_ff @(posedge clk) begin
		if (srst) begin
			bit_cnt_r <= '0;
			rx_r      <= '0;
		end else if (cs_fall || cs_rise) begin
			bit_cnt_r <= '0;
		end else if (sck_rise) begin
			rx_r <= {rx_r[14:0], sdi_s};
			if (bit_cnt_r != 5'd17) begin
				bit_cnt_r <= bit_cnt_r + 1'b1;
			end
		end
	end

	// Snapshot so that status register answers show state at frame start
	always_ff @(posedge clk) begin
		if (srst) begin
			snap_r <= '0;
		end else if (cs_fall) begin
			snap_r <= status_regs;
		end
	end

	// Transmit word: status byte at start, payload on the eighth rising edge
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_r <= '0;
		end else if (cs_fall) begin
			tx_r <= {global_status_byte, 8'h00};
		end else if (sck_rise && (bit_cnt_r == 5'd7)) begin
			tx_r[7:0] <= respond(hdr, ctrl_regs, snap_r);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sdo_out  <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else if (cs_fall) begin
			sdo_out  <= global_status_byte[7];
			sdo_oe_n <= 1'b0;
		end else if (cs_rise || to_event || !active_r) begin
			sdo_oe_n <= 1'b1;
		end else if (sck_fall && (bit_cnt_r != 5'd0) && (bit_cnt_r < 5'd16)) begin
			sdo_out <= tx_r[4'(15 - bit_cnt_r)];
		end
	end

	// One accepted frame waits here until the FIFO has room
	assign exec    = pend_r && fifo_in_ready;
	assign ex_op   = pend_word_r[15:14];
	assign ex_addr = pend_word_r[13:8];
	assign ex_data = pend_word_r[7:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			pend_r      <= 1'b0;
			pend_word_r <= '0;
		end else if (frame_ok && (!pend_r || exec)) begin
			pend_r      <= 1'b1;
			pend_word_r <= rx_r;
		end else if (exec) begin
			pend_r <= 1'b0;
		end
	end

	// Set wins over clear so no error is lost
	always_ff @(posedge clk) begin
		if (srst) begin
			interface_error_bit <= 1'b0;
		end else if (frame_bad || to_event || (frame_ok && pend_r && !exec)) begin
			interface_error_bit <= 1'b1;
		end else if (frame_ok) begin
			interface_error_bit <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rst_flag_r <= 1'b1;
		end else if (frame_ok) begin
			rst_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_regs <= {CN{spi_frame_pkg::CTRL_RST}};
		end else if (exec && (ex_op == spi_frame_pkg::OP_INFO) && (ex_addr == spi_frame_pkg::ADDR_ALL)) begin
			for (int i = 0; i < CN; i++) begin
				if (i != spi_frame_pkg::KEEP_CTRL_IDX) begin
					ctrl_regs[i*8 +: 8] <= spi_frame_pkg::CTRL_RST;
				end
			end
			ctrl_regs[spi_frame_pkg::DSFD_REG_IDX*8 + spi_frame_pkg::DSFD_BIT] <=
				ctrl_regs[spi_frame_pkg::DSFD_REG_IDX*8 + spi_frame_pkg::DSFD_BIT];
		end else if (exec && (ex_op == spi_frame_pkg::OP_WRITE)) begin
			for (int i = 0; i < CN; i++) begin
				if (ctrl_hit(ex_addr, i)) begin
					ctrl_regs[i*8 +: 8] <= ex_data;
				end
			end
		end
	end

	always_comb begin
		clr_mask = '0;
		if (exec && (ex_op == spi_frame_pkg::OP_RDCLR)) begin
			for (int i = 0; i < SN; i++) begin
				if (ex_addr == spi_frame_pkg::ADDR_ALL) begin
					clr_mask[i*8 +: 8] = 8'hFF;
				end else if (stat_hit(ex_addr, i)) begin
					clr_mask[i*8 +: 8] = ex_data;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			status_regs <= '0;
		end else begin
			status_regs <= (status_regs & ~clr_mask) | status_event;
		end
	end

	frame_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (pend_r),
		.in_ready  (fifo_in_ready),
		.in_data   (FIFO_W'(pend_word_r)),
		.out_valid (cmd_valid),
		.out_ready (cmd_ready),
		.out_data  (cmd_data)
	);

	property p_idle_float;
		@(posedge clk) disable iff (srst) !active_r && !cs_fall |=> sdo_oe_n;
	endproperty
	a_idle_float: assert property (p_idle_float) else $error("output driven while deselected");

	property p_start_drive;
		@(posedge clk) disable iff (srst) cs_fall |=> !sdo_oe_n && (sdo_out == ~|$past(status_low));
	endproperty
	a_start_drive: assert property (p_start_drive) else $error("first bit wrong at frame start");

	property p_timeout_float;
		@(posedge clk) disable iff (srst) to_event && !cs_rise |=> sdo_oe_n && timeout_r;
	endproperty
	a_timeout_float: assert property (p_timeout_float) else $error("timeout left output driven");

	property p_count_restart;
		@(posedge clk) disable iff (srst) cs_rise |=> (bit_cnt_r == 5'd0) && !active_r;
	endproperty
	a_count_restart: assert property (p_count_restart) else $error("counter not restarted");

	property p_bad_count;
		@(posedge clk) disable iff (srst)
			cs_rise && active_r && (bit_cnt_r != 5'd0) && (bit_cnt_r != 5'd16) |=> interface_error_bit && !pend_r;
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("bad count not flagged");

	property p_status_hold;
		@(posedge clk) disable iff (srst)
			active_r && (bit_cnt_r >= 5'd8) && !cs_fall ##1 active_r |-> tx_r[15:8] == $past(tx_r[15:8]);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status byte moved in frame");

	property p_read_only;
		@(posedge clk) disable iff (srst)
			exec && (ex_op == spi_frame_pkg::OP_READ) |=> ctrl_regs == $past(ctrl_regs);
	endproperty
	a_read_only: assert property (p_read_only) else $error("read changed control");

	property p_write_lands;
		@(posedge clk) disable iff (srst)
			exec && (ex_op == spi_frame_pkg::OP_WRITE) && (ex_addr == spi_frame_pkg::CTRL_BASE)
			|=> ctrl_regs[7:0] == $past(ex_data);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not stored");

	property p_invalid_no_exec;
		@(posedge clk) disable iff (srst) frame_bad && !pend_r |=> !pend_r ##1 !exec;
	endproperty
	a_invalid_no_exec: assert property (p_invalid_no_exec) else $error("invalid frame executed");

	property p_clear_all;
		@(posedge clk) disable iff (srst)
			exec && (ex_op == spi_frame_pkg::OP_RDCLR) && (ex_addr == spi_frame_pkg::ADDR_ALL)
			|=> status_regs == $past(status_event);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("status not all cleared");
endmodule
`default_nettype wire

//--- spi_frame_pkg.sv
// Constants shared by the frame slave, its FIFO and its synchroniser
package spi_frame_pkg;
	localparam int         FRAME_BITS    = 16;
	localparam int         CNT_W         = 5;
	localparam logic [1:0] OP_READ       = 2'h0;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [1:0] OP_RDCLR      = 2'h2;
	localparam logic [1:0] OP_INFO       = 2'h3;
	localparam logic [5:0] ADDR_ALL      = 6'h3F;
	localparam logic [5:0] CTRL_BASE     = 6'h01;
	localparam logic [5:0] STAT_BASE     = 6'h11;
	localparam int         CTRL_N        = 8;
	localparam int         STAT_N        = 7;
	localparam logic [7:0] CTRL_RST      = 8'h00;
	localparam int         KEEP_CTRL_IDX = 0;
	localparam int         DSFD_REG_IDX  = 1;
	localparam int         DSFD_BIT      = 0;
	localparam logic [5:0] INFO_ID_ADDR  = 6'h00;
	localparam logic [5:0] INFO_SPI_ADDR = 6'h01;
	localparam logic [5:0] INFO_WD_ADDR  = 6'h02;
	localparam logic [7:0] INFO_SPI_VAL  = 8'h10;
	localparam int         STS_RST_BIT   = 6;
	localparam int         STS_IFERR_BIT = 5;
	localparam logic [2:0] PIN_IDLE      = 3'h4;
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         CS_TIMEOUT_NS = 10_000_000;
	localparam int         FIFO_DEPTH    = 16;
	localparam int         TO_CNT_W      = 24;
endpackage

//--- sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0 // Idle levels of the pins
) (
	input  wire logic         clk,  // System clock
	input  wire logic         srst, // Synchronous reset
	input  wire logic [W-1:0] d,    // Asynchronous inputs
	output logic      [W-1:0] q     // Synchronised outputs
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			// Idle levels, so no false edge follows reset
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- frame_fifo.sv
// Synchronous FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input  wire logic         clk,       // System clock
	input  wire logic         srst,      // Synchronous reset
	input  wire logic         in_valid,  // Write request
	output logic              in_ready,  // Room for a word
	input  wire logic [W-1:0] in_data,   // Write data
	output logic              out_valid, // Output word valid
	input  wire logic         out_ready, // Consumer takes word
	output logic      [W-1:0] out_data   // Output word
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;

	assign in_ready = (count_r != (AW+1)'(D));
	assign push     = in_valid && in_ready;
	assign pop      = (count_r != '0) && (!out_valid || out_ready);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- spi_master_model.sv
// Serial bus master model that drives frames into the slave pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	input  wire logic clk,             // System clock
	output logic      chip_select_low, // Chip select, active low
	output logic      sck,             // Serial clock, idle low
	output logic      sdi,             // Serial data to slave
	input  wire logic sdo              // Resolved data line from slave
);
	initial begin
		chip_select_low = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Hold keeps select low before clocking, used to provoke a timeout
	task automatic xfer(input logic [15:0] word, input int pulses, input int hold, output logic [15:0] resp);
		resp = 16'h0000;
		chip_select_low <= 1'b0;
		wait_clk(8 + hold);
		for (int i = 0; i < pulses; i++) begin
			sdi <= word[15 - i];
			wait_clk(4);
			sck <= 1'b1;
			resp = {resp[14:0], sdo};
			wait_clk(4);
			sck <= 1'b0;
		end
		wait_clk(4);
		chip_select_low <= 1'b1;
		sdi <= ~sdi;
		wait_clk(8);
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the frame slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] ID_V = 8'h3C; // Arbitrary identification value
	logic        clk;
	logic        srst;
	logic [3:0]  flags_v;
	logic [55:0] status_event;
	logic        cmd_ready;
	wire         csl;
	wire         sck;
	wire         sdi;
	wire         sdo_line;
	logic        sdo_out;
	logic        sdo_oe_n;
	logic [63:0] ctrl_regs;
	logic [55:0] status_regs;
	logic        interface_error_bit;
	logic        cmd_valid;
	logic [15:0] cmd_data;
	logic        sdo_last_r = 1'b0;
	logic [15:0] resp;
	logic [63:0] exp_ctrl;
	int          err_total = 0;
	int          checks_done = 0;
	int          n;
	int          cnt;
	// Released line shows the inverse of its last level, never a guess
	always @(posedge clk) if (!sdo_oe_n) sdo_last_r <= sdo_out;
	assign sdo_line = sdo_oe_n ? ~sdo_last_r : sdo_out;
	spi_master_model m (.clk(clk), .chip_select_low(csl), .sck(sck), .sdi(sdi), .sdo(sdo_line));
	spi_frame_slave #(.TIMEOUT_CYC(200), .INFO_ID_VAL(ID_V), .INFO_WD_VAL(8'h00)) dut (
		.clk(clk), .srst(srst), .chip_select_low(csl), .sck(sck), .sdi(sdi),
		.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .flag_fe(flags_v[3]), .flag_de(flags_v[2]),
		.flag_gw(flags_v[1]), .flag_fs(flags_v[0]), .status_event(status_event), .ctrl_regs(ctrl_regs),
		.status_regs(status_regs), .interface_error_bit(interface_error_bit), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic summarize();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic fr(input logic [15:0] w, input logic [15:0] exp);
		m.xfer(w, 16, 0, resp);
		chk(resp, exp);
	endtask
	task automatic ev(input int idx, input logic [7:0] v);
		@(posedge clk);
		status_event[idx*8 +: 8] <= v;
		@(posedge clk);
		status_event <= '0;
		// One more edge so the caller sees the updated registers
		@(posedge clk);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		summarize();
	end
	initial begin
		srst = 1'b1;
		flags_v = 4'h0;
		status_event = '0;
		cmd_ready = 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk(sdo_oe_n, 1'b1);
		chk(ctrl_regs, 64'h0);
		chk(status_regs, 56'h0);
		fr(16'hC100, 16'h4010);
		fr(16'hC000, {8'h80, ID_V});
		fr(16'hC200, 16'h8000);
		fr(16'hC500, 16'h8000);
		for (int i = 0; i < 8; i++) begin
			exp_ctrl[i*8 +: 8] = {i[3:0] + 4'h1, 4'h3};
			fr({2'b01, 6'(i + 1), exp_ctrl[i*8 +: 8]}, 16'h8000);
		end
		chk(ctrl_regs, exp_ctrl);
		fr(16'h4177, 16'h8013);
		fr(16'h4113, 16'h8077);
		for (int i = 0; i < 8; i++) begin
			fr({2'b00, 6'(i + 1), 8'h00}, {8'h80, exp_ctrl[i*8 +: 8]});
		end
		fr(16'h51FF, 16'h8000);
		fr(16'h7FFF, 16'h8000);
		fr(16'h4AFF, 16'h8000);
		chk(ctrl_regs, exp_ctrl);
		chk(status_regs, 56'h0);
		ev(0, 8'h0F);
		ev(5, 8'h81);
		chk(status_regs, 56'h00_81_00_00_00_00_0F);
		fr(16'h1100, 16'h800F);
		fr(16'h9105, 16'h800F);
		chk(status_regs[7:0], 8'h0A);
		fork
			fr(16'h910B, 16'h800A);
			begin
				repeat (60) @(posedge clk);
				ev(0, 8'h01);
			end
		join
		chk(status_regs[7:0], 8'h00);
		fr(16'h1100, 16'h8000);
		ev(2, 8'h3C);
		fr(16'hBF00, 16'h8000);
		chk(status_regs, 56'h0);
		fr(16'hFF00, 16'h8000);
		exp_ctrl = {48'h0, 8'h01, 8'h13};
		chk(ctrl_regs, exp_ctrl);
		m.xfer(16'h41FF, 15, 0, resp);
		chk(ctrl_regs, exp_ctrl);
		chk(interface_error_bit, 1'b1);
		fr(16'h0100, 16'h2013);
		chk(interface_error_bit, 1'b0);
		m.xfer(16'h0000, 0, 0, resp);
		chk(interface_error_bit, 1'b0);
		m.xfer(16'hFFFF, 16, 0, resp);
		chk(ctrl_regs, exp_ctrl);
		chk(interface_error_bit, 1'b1);
		fr(16'h0100, 16'h2013);
		fork
			m.xfer(16'h0000, 0, 250, resp);
			begin
				repeat (20) @(posedge clk);
				chk(sdo_oe_n, 1'b0);
				repeat (220) @(posedge clk);
				chk(sdo_oe_n, 1'b1);
			end
		join
		chk(interface_error_bit, 1'b1);
		fr(16'h0100, 16'h2013);
		for (int k = 0; k < 4; k++) begin
			flags_v <= 4'h8 >> k;
			fr(16'h0100, {4'h0, 4'h8 >> k, 8'h13});
		end
		flags_v <= 4'h0;
		// Consumer stalls so the queue must fill and refuse
		cmd_ready <= 1'b0;
		n = 0;
		while (interface_error_bit !== 1'b1 && n < 24) begin
			m.xfer(16'h0300, 16, 0, resp);
			n++;
		end
		// Queue, output stage and pending slot fill, then one frame is refused
		chk(n, spi_frame_pkg::FIFO_DEPTH + 3);
		cnt = 0;
		cmd_ready <= 1'b1;
		repeat (40) begin
			@(posedge clk);
			if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
				cnt++;
				chk(cmd_data, 16'h0300);
			end
		end
		chk(cnt, spi_frame_pkg::FIFO_DEPTH + 2);
		chk(cmd_valid, 1'b0);
		fr(16'h0100, 16'h2013);
		summarize();
	end
endmodule
`default_nettype wire
